// ==== common/sensor_cfg_pkg.sv ====
// Constants, field layout and types for the sensor configuration decoder.
// Assumes a single 125 MHz core clock and a 32-bit configuration image
// delivered once from the fuse array after power-up.
package sensor_cfg_pkg;
   // Clock rate and the documented times
   localparam int CLK_MHZ = 125;                        // Core clock, MHz
   localparam int DETECT_TIME_US = 6000;                // Detect pull-down time, us (6 ms)
   localparam int TX_PERIOD_US = 228;                   // Free-running message period, us
   localparam int DETECT_CYCLES = DETECT_TIME_US * CLK_MHZ;  // Least time, exact
   localparam int TX_PERIOD_CYCLES = TX_PERIOD_US * CLK_MHZ; // Period, exact

   // Register byte addresses on the AXI4-Lite slave
   localparam logic [7:0] ADDR_CFG_IMAGE = 8'h00;       // Loaded configuration image
   localparam logic [7:0] ADDR_STATUS = 8'h04;          // Decoded state
   localparam logic [7:0] ADDR_MSG = 8'h08;             // Message word in, check bits out
   localparam logic [7:0] ADDR_DEVDATA = 8'h0C;         // Device byte in, placed field out
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Field positions in the configuration image
   localparam int POS_USER = 0;                         // User byte [7:0]
   localparam int POS_DLY = 8;                          // Slot delay code [10:8]
   localparam int POS_FIXED_SLOT_DELAY_ENABLE = 11;
   localparam int POS_MD = 12;                          // Device data mode [13:12]
   localparam int POS_BDE = 14;
   localparam int POS_RSV = 15;                         // Reserved phase-2 bit
   localparam int POS_DAT = 17;
   localparam int POS_SVD = 18;
   localparam int POS_ERC = 19;
   localparam int POS_SECOND_DEVICE_DETECT_ENABLE = 20;
   localparam int POS_SYNC_PULSE_ENABLE = 21;
   localparam int POS_AZE = 22;
   localparam int POS_STI = 23;
   localparam int POS_RG = 24;                          // Range code [26:24]
   localparam int POS_FC = 27;                          // Filter code [28:27]
   localparam int POS_ANALOG_TAP_OUTPUT_ENABLE = 29;
   localparam int POS_OTP_PARITY_BIT = 30;
   localparam int POS_LOCK = 31;

   // Mode codes
   localparam logic [1:0] MODE_FULL_CFG = 2'h0;
   localparam logic [1:0] MODE_RANGE = 2'h1;
   localparam logic [1:0] MODE_CODED8 = 2'h2;
   localparam logic [1:0] MODE_CODED10 = 2'h3;
   localparam logic [1:0] ST_DEVICE_OK = 2'h0;          // Self-test phase payload kinds
   localparam logic [1:0] ST_RANGE = 2'h1;
   localparam logic [1:0] ST_DELIMITER = 2'h2;
   localparam logic [2:0] PHASE_AUTO_ZERO = 3'h4;
   localparam logic [2:0] PHASE_NORMAL = 3'h5;
   localparam logic [2:0] RANGE_UNUSED = 3'h7;
   localparam logic [3:0] CRC_POLY = 4'hB;              // x^3 + x + 1

   // Controller states, one-hot
   typedef enum logic [2:0] {
      ST_WAIT_LOAD = 3'h1,
      ST_DETECT = 3'h2,
      ST_RUN = 3'h4
   } ctrl_e;
endpackage : sensor_cfg_pkg

// ==== design/sensor_config_field_decode.sv ====
// Configuration field decoder with an AXI4-Lite register view.
// Assumes the fuse image arrives on OTP_WORD_I with a one-cycle OTP_LOAD_I
// from logic on the same clock; SYNC_PULSE_I comes from the bus receiver pin.
//
// Summary of operation
// - Discharge only when sync mode also enabled
// - Discharge switches current after valid sync pulse
// - Fixed delay shifts slot by delay code
// - Detect enable draws pull-down for 6 ms
// - Internal self-test judged here, external by receiver
// - Self-test payload by mode: OK/range/delimiter/OK
// - Filter code gives 400/200/100/800 Hz
// - Range code maps to g range, 111 unused
// - Mode code selects startup payload content
// - Full range only with state vectors, auto-zero off
// - Mode 3 with 8-bit data: config error
// - Device byte left-justified in 10 bits in 10-bit mode, right-justified in 8-bit mode
// - Free-running message every 228 us
// - Sync mode transmits only per sync pulse
// - Auto-zero off skips straight to normal data
// - Check clear appends 3-bit CRC
// - Check set appends even parity bit
// - Width bit selects 10-bit or 8-bit data
// - State-vector-off omits vectors, reduced range
// - Lock bit reads fuse programmed state
// - Reserved bit sent in coded modes
// - Unprogrammed bits default zero
module sensor_config_field_decode
   import sensor_cfg_pkg::*;
#(
   parameter int DETECT_CYC = DETECT_CYCLES,            // Shorten for simulation
   parameter int TX_PERIOD_CYC = TX_PERIOD_CYCLES       // Shorten for simulation
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic [31:0] OTP_WORD_I,
   input wire logic OTP_LOAD_I,
   input wire logic SYNC_PULSE_I,
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   output logic TX_START_O,
   output logic SIGNAL_CURRENT_O,
   output logic DETECT_PULLDOWN_O,
   output logic SLOT_DELAY_EN_O,
   output logic [2:0] SLOT_DELAY_CODE_O,
   output logic SELFTEST_JUDGE_O,
   output logic [1:0] SELFTEST_PAYLOAD_O,
   output logic [9:0] FILTER_HZ_O,
   output logic [9:0] RANGE_G_O,
   output logic [1:0] STARTUP_PAYLOAD_O,
   output logic RESERVED_SEND_O,
   output logic FULL_RANGE_O,
   output logic CONFIG_ERROR_O,
   output logic SENSOR_DATA_EN_O,
   output logic SENSOR_10BIT_O,
   output logic STATE_VECTOR_EN_O,
   output logic [2:0] PHASE_AFTER_SELFTEST_O,
   output logic CHECK_PARITY_O,
   output logic OTP_LOCK_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Corner frequency in Hz from the two-bit code
   function automatic logic [9:0] filter_hz(input logic [1:0] fc);
      case (fc)
         2'h0: filter_hz = 10'h190;  // 400 Hz
         2'h1: filter_hz = 10'h0C8;  // 200 Hz
         2'h2: filter_hz = 10'h064;  // 100 Hz
         default: filter_hz = 10'h320;  // 800 Hz
      endcase
   endfunction : filter_hz

   // Full-scale range in g; zero for the unused code
   function automatic logic [9:0] range_g(input logic [2:0] rg);
      case (rg)
         3'h0: range_g = 10'h032;  // 50 g
         3'h1: range_g = 10'h064;  // 100 g
         3'h2: range_g = 10'h0FA;  // 250 g
         3'h3: range_g = 10'h096;  // 150 g
         3'h4: range_g = 10'h0C8;  // 200 g
         3'h5: range_g = 10'h15E;  // 350 g
         3'h6: range_g = 10'h1F4;  // 500 g
         default: range_g = 10'h000;  // Not used
      endcase
   endfunction : range_g

   // Three-bit CRC over a 16-bit message, MSB first, zero seed
   function automatic logic [2:0] crc3(input logic [15:0] msg);
      logic [3:0] acc;
      acc = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         acc = {acc[2:0], msg[i]};
         if (acc[3]) begin
            acc = acc ^ CRC_POLY;
         end
      end
      for (int i = 0; i < 3; i++) begin
         acc = {acc[2:0], 1'b0};
         if (acc[3]) begin
            acc = acc ^ CRC_POLY;
         end
      end
      crc3 = acc[2:0];
   endfunction : crc3

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      ctrl_e ctrl;               // Controller state
      logic [31:0] cfg;          // Loaded configuration image
      logic sync_meta;           // Synchroniser stage 1
      logic sync_s;              // Synchroniser stage 2
      logic sync_d;              // Edge detect delay
      logic [19:0] det_cnt;      // Detect pull-down timer
      logic [19:0] tx_cnt;       // Free-running period timer
      logic tx_start;
      logic sig_cur;
      logic det_pd;
      logic [15:0] msg;          // Software message word
      logic [2:0] check;         // Check bits for msg
      logic [7:0] dev_byte;      // Software device byte
      logic [9:0] dev_field;     // Placed device field
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic aw_rdy;
      logic w_rdy;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_s;

   state_s st_reg;  // Registered state
   state_s st_next; // Next state

   // Decoded fields of the loaded image, and the sync pulse edge
   logic [1:0] md;
   logic cfg_err;
   logic full_rng;
   logic sync_edge;
   assign md = st_reg.cfg[POS_MD +: 2];
   assign sync_edge = st_reg.sync_s & ~st_reg.sync_d;

   // Mode 0 with vectors off, or mode 3 with 8-bit data, is inconsistent
   assign cfg_err = (md == MODE_FULL_CFG && st_reg.cfg[POS_SVD]) ||
                    (md == MODE_CODED10 && st_reg.cfg[POS_DAT]);
   assign full_rng = ~st_reg.cfg[POS_SVD] & ~st_reg.cfg[POS_AZE];

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      logic [31:0] st_word;
      st_word = 32'h0000_0000;
      st_next = st_reg;
      // Synchroniser: only stage 2 reads stage 1
      st_next.sync_meta = SYNC_PULSE_I;
      st_next.sync_s = st_reg.sync_meta;
      st_next.sync_d = st_reg.sync_s;
      st_next.tx_start = 1'b0;
      st_next.sig_cur = 1'b0;

      // Controller
      case (st_reg.ctrl)
         ST_WAIT_LOAD: begin
            // Image taken once; later loads are ignored
            if (OTP_LOAD_I) begin
               st_next.cfg = OTP_WORD_I;
               st_next.det_cnt = 20'h0_0000;
               st_next.det_pd = OTP_WORD_I[POS_SECOND_DEVICE_DETECT_ENABLE];
               st_next.ctrl = OTP_WORD_I[POS_SECOND_DEVICE_DETECT_ENABLE] ? ST_DETECT : ST_RUN;
            end
         end
         ST_DETECT: begin
            // Pull-down held for the detect window
            if (st_reg.det_cnt == 20'(DETECT_CYC - 1)) begin
               st_next.det_pd = 1'b0;
               st_next.ctrl = ST_RUN;
            end else begin
               st_next.det_cnt = st_reg.det_cnt + 20'h0_0001;
            end
         end
         ST_RUN: begin
            if (st_reg.cfg[POS_SYNC_PULSE_ENABLE]) begin
               // Sync mode: one message per recognised pulse
               st_next.tx_start = sync_edge;
               st_next.sig_cur = sync_edge & st_reg.cfg[POS_BDE];
            end else if (st_reg.tx_cnt == 20'(TX_PERIOD_CYC - 1)) begin
               // Free-running period from the internal clock
               st_next.tx_cnt = 20'h0_0000;
               st_next.tx_start = 1'b1;
            end else begin
               st_next.tx_cnt = st_reg.tx_cnt + 20'h0_0001;
            end
         end
         default: begin
            st_next.ctrl = ST_WAIT_LOAD;
         end
      endcase

      // Check bits follow the message word and check type
      st_next.check = st_reg.cfg[POS_ERC] ? {2'h0, ^st_reg.msg}
                                          : crc3(st_reg.msg);
      // Device byte placed for the selected data width
      st_next.dev_field = st_reg.cfg[POS_DAT] ? {2'h0, st_reg.dev_byte}
                                              : {st_reg.dev_byte, 2'h0};

      // AXI write: address and data taken in either order
      if (S_AXI_AWVALID_I && st_reg.aw_rdy) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && st_reg.w_rdy) begin
         st_next.w_have = 1'b1;
         st_next.w_data = S_AXI_WDATA_I;
         st_next.w_strb = S_AXI_WSTRB_I;
      end
      if (st_reg.bvalid && S_AXI_BREADY_I) begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
         // Both halves present: perform and answer
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OKAY;
         case (st_reg.aw_addr & 8'hFC)
            ADDR_MSG: begin
               if (st_reg.w_strb[0]) st_next.msg[7:0] = st_reg.w_data[7:0];
               if (st_reg.w_strb[1]) st_next.msg[15:8] = st_reg.w_data[15:8];
            end
            ADDR_DEVDATA: begin
               if (st_reg.w_strb[0]) st_next.dev_byte = st_reg.w_data[7:0];
            end
            ADDR_CFG_IMAGE, ADDR_STATUS: begin
               // Read-only: image frozen after load
               st_next.bresp = RESP_OKAY;
            end
            default: begin
               st_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      st_next.aw_rdy = ~st_next.aw_have & ~st_next.bvalid;
      st_next.w_rdy = ~st_next.w_have & ~st_next.bvalid;

      // AXI read
      st_word = {22'h00_0000, st_reg.ctrl, st_reg.det_pd, full_rng, cfg_err,
                 st_reg.cfg[POS_LOCK], st_reg.ctrl != ST_WAIT_LOAD, st_reg.cfg[POS_ANALOG_TAP_OUTPUT_ENABLE],
                 st_reg.cfg[POS_STI]};
      if (st_reg.rvalid && S_AXI_RREADY_I) begin
         st_next.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID_I && st_reg.ar_rdy) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         case (S_AXI_ARADDR_I & 8'hFC)
            ADDR_CFG_IMAGE: st_next.rdata = st_reg.cfg;
            ADDR_STATUS: st_next.rdata = st_word;
            ADDR_MSG: st_next.rdata = {13'h0000, st_reg.check, st_reg.msg};
            ADDR_DEVDATA: st_next.rdata = {22'h00_0000, st_reg.dev_field};
            default: begin
               st_next.rdata = 32'h0000_0000;
               st_next.rresp = RESP_SLVERR;
            end
         endcase
      end
      st_next.ar_rdy = ~st_next.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; unprogrammed image reads all zero

   always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_reg <= '{ctrl: ST_WAIT_LOAD, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered decoded outputs

   always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SLOT_DELAY_EN_O <= 1'b0;
         SLOT_DELAY_CODE_O <= 3'h0;
         SELFTEST_JUDGE_O <= 1'b0;
         SELFTEST_PAYLOAD_O <= 2'h0;
         FILTER_HZ_O <= 10'h000;
         RANGE_G_O <= 10'h000;
         STARTUP_PAYLOAD_O <= 2'h0;
         RESERVED_SEND_O <= 1'b0;
         FULL_RANGE_O <= 1'b0;
         CONFIG_ERROR_O <= 1'b0;
         SENSOR_DATA_EN_O <= 1'b0;
         SENSOR_10BIT_O <= 1'b0;
         STATE_VECTOR_EN_O <= 1'b0;
         PHASE_AFTER_SELFTEST_O <= 3'h0;
         CHECK_PARITY_O <= 1'b0;
         OTP_LOCK_O <= 1'b0;
      end else begin
         SLOT_DELAY_EN_O <= st_reg.cfg[POS_FIXED_SLOT_DELAY_ENABLE];
         SLOT_DELAY_CODE_O <= st_reg.cfg[POS_FIXED_SLOT_DELAY_ENABLE] ? st_reg.cfg[POS_DLY +: 3] : 3'h0;
         SELFTEST_JUDGE_O <= st_reg.cfg[POS_STI];
         // Range for mode 1, delimiter for mode 2, device OK otherwise
         SELFTEST_PAYLOAD_O <= (md == MODE_RANGE) ? ST_RANGE :
                               (md == MODE_CODED8) ? ST_DELIMITER : ST_DEVICE_OK;
         FILTER_HZ_O <= filter_hz(st_reg.cfg[POS_FC +: 2]);
         RANGE_G_O <= range_g(st_reg.cfg[POS_RG +: 3]);
         STARTUP_PAYLOAD_O <= md;
         RESERVED_SEND_O <= md[1];
         FULL_RANGE_O <= full_rng;
         CONFIG_ERROR_O <= cfg_err;
         SENSOR_DATA_EN_O <= st_reg.ctrl == ST_RUN && !cfg_err;
         SENSOR_10BIT_O <= ~st_reg.cfg[POS_DAT];
         STATE_VECTOR_EN_O <= ~st_reg.cfg[POS_SVD];
         PHASE_AFTER_SELFTEST_O <= st_reg.cfg[POS_AZE] ? PHASE_AUTO_ZERO : PHASE_NORMAL;
         CHECK_PARITY_O <= st_reg.cfg[POS_ERC];
         OTP_LOCK_O <= st_reg.cfg[POS_LOCK];
      end
   end

   // Struct fields straight to ports
   assign S_AXI_AWREADY_O = st_reg.aw_rdy;
   assign S_AXI_WREADY_O = st_reg.w_rdy;
   assign S_AXI_BVALID_O = st_reg.bvalid;
   assign S_AXI_BRESP_O = st_reg.bresp;
   assign S_AXI_ARREADY_O = st_reg.ar_rdy;
   assign S_AXI_RVALID_O = st_reg.rvalid;
   assign S_AXI_RDATA_O = st_reg.rdata;
   assign S_AXI_RRESP_O = st_reg.rresp;
   assign TX_START_O = st_reg.tx_start;
   assign SIGNAL_CURRENT_O = st_reg.sig_cur;
   assign DETECT_PULLDOWN_O = st_reg.det_pd;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);

   AST_DISCHARGE_NEEDS_SYNC: assert property (SIGNAL_CURRENT_O |-> st_reg.cfg[POS_BDE] && st_reg.cfg[POS_SYNC_PULSE_ENABLE])
      else $error("Discharge current without sync mode");
   AST_DISCHARGE_ON_PULSE: assert property (sync_edge && st_reg.ctrl == ST_RUN && st_reg.cfg[POS_BDE]
      && st_reg.cfg[POS_SYNC_PULSE_ENABLE] |=> SIGNAL_CURRENT_O && TX_START_O)
      else $error("Sync pulse did not switch bus current");
   AST_SLOT_DELAY_OFF: assert property (!st_reg.cfg[POS_FIXED_SLOT_DELAY_ENABLE] |=> SLOT_DELAY_CODE_O == 3'h0)
      else $error("Slot delay applied while fixed delay is off");
   AST_DETECT_WINDOW: assert property ($rose(DETECT_PULLDOWN_O) |-> DETECT_PULLDOWN_O [*8])
      else $error("Detect pull-down ended early");
   AST_NO_DETECT: assert property (DETECT_PULLDOWN_O |-> st_reg.cfg[POS_SECOND_DEVICE_DETECT_ENABLE])
      else $error("Detect current without detect enable");
   AST_SELFTEST_MODE2: assert property (md == MODE_CODED8 |=> SELFTEST_PAYLOAD_O == ST_DELIMITER)
      else $error("Wrong self-test payload for mode 2");
   AST_FILTER_800: assert property (st_reg.cfg[POS_FC +: 2] == 2'h3 |=> FILTER_HZ_O == 10'h320)
      else $error("Filter code 3 not 800 Hz");
   AST_RANGE_500: assert property (st_reg.cfg[POS_RG +: 3] == 3'h6 |=> RANGE_G_O == 10'h1F4)
      else $error("Range code 6 not 500 g");
   AST_MODE0_SVD_ERR: assert property (md == MODE_FULL_CFG && st_reg.cfg[POS_SVD] |=> CONFIG_ERROR_O
      && !FULL_RANGE_O)
      else $error("Mode 0 with vectors off not flagged");
   AST_MODE3_8BIT: assert property (md == MODE_CODED10 && st_reg.cfg[POS_DAT] |=> CONFIG_ERROR_O
      && !SENSOR_DATA_EN_O)
      else $error("Mode 3 with 8-bit data sends sensor data");
   AST_FREE_RUN: assert property (st_reg.ctrl == ST_RUN && !st_reg.cfg[POS_SYNC_PULSE_ENABLE] && $rose(TX_START_O)
      |=> !TX_START_O [*2])
      else $error("Free-running start not a single pulse");
   AST_SYNC_ONLY: assert property (TX_START_O && st_reg.cfg[POS_SYNC_PULSE_ENABLE] |-> $past(sync_edge))
      else $error("Transmission in sync mode without pulse");
   AST_PARITY_EVEN: assert property (st_reg.cfg[POS_ERC] ##1 $stable(st_reg.msg) |->
      ^{st_reg.msg, st_reg.check[0]} == 1'b0)
      else $error("Parity bit does not give even parity");
   AST_LOCK_BIT: assert property (##1 OTP_LOCK_O == $past(st_reg.cfg[POS_LOCK]))
      else $error("Lock bit mismatch");
   AST_DEFAULT_ZERO: assert property (st_reg.ctrl == ST_WAIT_LOAD |-> st_reg.cfg == 32'h0000_0000)
      else $error("Image not zero before load");
   AST_HOLD_CFG: assert property (st_reg.ctrl != ST_WAIT_LOAD |=> $stable(st_reg.cfg))
      else $error("Configuration changed after load");

   COV_SYNC_TX: cover property (st_reg.cfg[POS_SYNC_PULSE_ENABLE] && TX_START_O);
   COV_FREE_TX: cover property (!st_reg.cfg[POS_SYNC_PULSE_ENABLE] && TX_START_O);
   COV_DETECT_END: cover property ($fell(DETECT_PULLDOWN_O));
   COV_CFG_ERR: cover property (CONFIG_ERROR_O);

endmodule : sensor_config_field_decode

// ==== tb/sync_pulse_source.sv ====
// Control-module stand-in: drives the sync pulse pin of the sensor.
// Assumes the bench raises fire_i for one cycle per wanted message.
module sync_pulse_source (
   input wire logic clk_i,
   input wire logic fire_i,
   input wire logic [2:0] gap_i,
   output logic sync_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_reg = -1; // Cycles left until the pulse ends
   // Line idles low, so a stale level never looks like a new pulse
   initial sync_o = 1'b0;
   // One four-cycle pulse per request, after a gap of gap_i cycles
   always @(posedge clk_i) begin
      if (fire_i) cnt_reg <= int'(gap_i) + 4;
      else if (cnt_reg >= 0) cnt_reg <= cnt_reg - 1;
      sync_o <= (cnt_reg > 0) && (cnt_reg <= 4);
   end
endmodule : sync_pulse_source

// ==== tb/test_sensor_config_field_decode.sv ====
// Self-checking bench for the configuration field decoder.
// Assumes short detect and period counts; one fuse image per reset.
module test_sensor_config_field_decode
   import sensor_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DET = 16; // Shortened detect time
   localparam int PER = 20; // Shortened free-run period
   logic clk = 1'b0, rst_n = 1'b0, load = 1'b0, fire = 1'b0, cfg_sync_pulse_enable = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] otp = 32'h0000_0000, wdata = 32'h0000_0000;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [2:0] gap = 3'h0;
   wire sync, awready, wready, bvalid, arready, rvalid, txs, sc, dpd;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [39:0] outs; // All decoded levels, packed
   int seed = 77, miscompares = 0, n_checks = 0, cyc = 0, last = 0, det_n, tx_n, sc_n;
   logic [1:0] bq[$]; // Expected write responses
   logic [33:0] rq[$]; // Expected read response and data
   logic [9:0] filt[4] = '{10'h190, 10'h0C8, 10'h064, 10'h320};
   logic [9:0] rng[8] = '{10'h032, 10'h064, 10'h0FA, 10'h096, 10'h0C8, 10'h15E, 10'h1F4, 10'h000};
   ////////////////////////////////////////////////////////////////////////////
   sensor_config_field_decode #(.DETECT_CYC(DET), .TX_PERIOD_CYC(PER)) uut (
      .CORE_CLK_I(clk), .RST_N_I(rst_n), .OTP_WORD_I(otp), .OTP_LOAD_I(load), .SYNC_PULSE_I(sync),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .TX_START_O(txs), .SIGNAL_CURRENT_O(sc), .DETECT_PULLDOWN_O(dpd),
      .SLOT_DELAY_EN_O(outs[39]), .SLOT_DELAY_CODE_O(outs[38:36]), .SELFTEST_JUDGE_O(outs[35]),
      .SELFTEST_PAYLOAD_O(outs[34:33]), .FILTER_HZ_O(outs[32:23]), .RANGE_G_O(outs[22:13]),
      .STARTUP_PAYLOAD_O(outs[12:11]), .RESERVED_SEND_O(outs[10]), .FULL_RANGE_O(outs[9]),
      .CONFIG_ERROR_O(outs[8]), .SENSOR_DATA_EN_O(outs[7]), .SENSOR_10BIT_O(outs[6]),
      .STATE_VECTOR_EN_O(outs[5]), .PHASE_AFTER_SELFTEST_O(outs[4:2]), .CHECK_PARITY_O(outs[1]),
      .OTP_LOCK_O(outs[0]));
   sync_pulse_source partner (.clk_i(clk), .fire_i(fire), .gap_i(gap), .sync_o(sync));
   ////////////////////////////////////////////////////////////////////////////
   // Free-running clock and cycle count
   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // Expected decoded levels for an image; run is low before loading
   function automatic logic [39:0] dec(input logic [31:0] w, input logic run);
      logic [1:0] md;
      logic cerr;
      md = w[13:12];
      cerr = (md == 2'h0 && w[18]) || (md == 2'h3 && w[17]);
      return {w[11], w[11] ? w[10:8] : 3'h0, w[23], (md == 2'h3) ? 2'h0 : md, filt[w[28:27]], rng[w[26:24]],
              md, md[1], !w[18] && !w[22], cerr, run && !cerr, !w[17], !w[18], w[22] ? 3'h4 : 3'h5, w[19], w[31]};
   endfunction : dec
   // Remainder of message times x^3, shifted in MSB first from zero
   function automatic logic [2:0] crc3(input logic [15:0] m);
      logic [2:0] r;
      logic fb;
      r = 3'h0;
      for (int i = 15; i >= 0; i--) begin
         fb = r[2] ^ m[i];
         r = {r[1:0], 1'b0} ^ {1'b0, fb, fb};
      end
      return r;
   endfunction : crc3
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      if (miscompares == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////
   // Bus writes: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ad, wd, ag, wg;
      ad = 1'b0;
      wd = 1'b0;
      bq.push_back(r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge clk);
         ag = awvalid && awready;
         wg = wvalid && wready;
         @(posedge clk);
         if (ag) awvalid <= 1'b0;
         if (wg) wvalid <= 1'b0;
         ad = ad || ag;
         wd = wd || wg;
      end
      do @(negedge clk); while (bvalid !== 1'b1);
      @(posedge clk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1);
      @(posedge clk);
      rready <= 1'b0;
   endtask : rd
   // Watcher: bus answers against the oldest note, plus pin event counts
   always @(negedge clk) begin
      if ((bvalid & bready) === 1'b1) check(bresp, bq.pop_front());
      if ((rvalid & rready) === 1'b1) check({rresp, rdata}, rq.pop_front());
      if (dpd === 1'b1) det_n++;
      if (sc === 1'b1) sc_n++;
      if (txs === 1'b1) begin
         if (!cfg_sync_pulse_enable && last > 0) check(cyc - last, PER);
         last = cyc;
         tx_n++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // One fuse image: reset, load, traffic, decode, registers
   task automatic run_one(input logic [31:0] w);
      logic [39:0] e;
      logic [15:0] m;
      logic [7:0] b;
      e = dec(w, 1'b1);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      det_n = 0;
      tx_n = 0;
      sc_n = 0;
      last = 0;
      cfg_sync_pulse_enable = w[21];
      repeat (2) @(posedge clk);
      @(negedge clk) check(outs, dec(32'h0000_0000, 1'b0));
      @(posedge clk) otp <= w;
      load <= 1'b1;
      @(posedge clk) load <= 1'b0;
      repeat (DET + 4) @(posedge clk);
      check(det_n, w[20] ? DET : 0);
      if (w[21]) begin
         repeat (2) begin
            @(posedge clk) fire <= 1'b1;
            gap <= 3'($random(seed));
            @(posedge clk) fire <= 1'b0;
            repeat (PER) @(posedge clk);
         end
         check(tx_n, 2);
      end else begin
         repeat (3 * PER + 10) @(posedge clk);
         check(tx_n > 1, 1'b1);
      end
      check(sc_n, (w[21] && w[14]) ? tx_n : 0);
      @(posedge clk) otp <= ~w;
      load <= 1'b1;
      @(posedge clk) load <= 1'b0;
      @(negedge clk) check(outs, e);
      wr(ADDR_CFG_IMAGE, ~w, RESP_OKAY);
      rd(ADDR_CFG_IMAGE, {RESP_OKAY, w});
      rd(ADDR_STATUS, {RESP_OKAY, 22'h00_0000, 3'h4, 1'b0, e[9], e[8], w[31], 1'b1, w[29], w[23]});
      m = 16'($random(seed));
      wr(ADDR_MSG, {16'h0000, m}, RESP_OKAY);
      rd(ADDR_MSG, {RESP_OKAY, 13'h0000, w[19] ? {2'h0, ^m} : crc3(m), m});
      b = 8'($random(seed));
      wr(ADDR_DEVDATA, {24'h00_0000, b}, RESP_OKAY);
      rd(ADDR_DEVDATA, {RESP_OKAY, 22'h00_0000, w[17] ? {2'h0, b} : {b, 2'h0}});
      wr(8'h10, w, RESP_SLVERR);
      rd(8'h10, {RESP_SLVERR, 32'h0000_0000});
   endtask : run_one
   // Main sequence; forced fields walk every filter, range and mode code,
   // and force sync, discharge and both configuration errors to occur
   initial begin
      logic [31:0] img;
      for (int i = 0; i < 9; i++) begin
         img = (i == 0) ? 32'h0000_0000 : $random(seed);
         img[13:12] = i[1:0];
         img[28:27] = i[2:1];
         img[26:24] = i[2:0];
         img[21] = i[0];
         img[14] = i[1];
         img[17] = i[2];
         img[18] = i[3];
         run_one(img);
      end
      conclude();
   end
   // Hang guard, well beyond the expected run length
   initial begin
      #(8 * 20000);
      miscompares++;
      conclude();
   end
endmodule : test_sensor_config_field_decode
